// File: hdl/mops_seq.sv
`timescale 1ns/10ps
// Contract
// - Target code is high byte plus two bits
// - Code commits only on low byte write
// - Master enable rise: bias, load, start
// - Manual start by enable bit, no delay
// - Pin mode one adds enable pins
// - Auto start with delays, power-up slew
// - Bit or pin low ramps output down
// - Manual power-down skips shutdown delay
// - Master fall: delay, ramp, then shutdown
// - Power-down ramp uses power-down slew
// - Below threshold: passive or weak pull-down
// - Code changes use rise or fall slew
// - Boot loads codes from stored defaults
// - Long watchdog restores first voltage set
// - Watchdog polarity configurable, all outputs
// - Unmasked faults drive configurable interrupt
// - Over-temperature stops all, restarts after; outputs in master power-down or ramp-down are not stopped
// - Overcurrent: high impedance, periodic retry
// - Overvoltage: crowbar, shut down, retry
// - Undervoltage: shut down, restart, window
// - Pin mode zero: pad selects access
module mops_seq #(
  parameter int BOOT_CYC_P = mops_pkg::BOOT_CYC,
  parameter int MS_CYC_P = mops_pkg::MS_CYC,
  parameter int WDOG_CYC_P = mops_pkg::WDOG_CYC,
  parameter int CROW_CYC_P = mops_pkg::CROW_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic master_en_pin,
  input wire logic en_a_pin,
  input wire logic en_b_pin,
  input wire logic watchdog_restore_pin,
  input wire logic interface_select_pad,
  input wire logic ot_fault,
  input wire logic [mops_pkg::NCH-1:0] oc_fault,
  input wire logic [mops_pkg::NCH-1:0] ov_fault,
  input wire logic [mops_pkg::NCH-1:0] uv_fault,
  input wire logic [mops_pkg::NCH-1:0] ramp_done,
  input wire logic [mops_pkg::NCH-1:0] below_250mv,
  input wire mops_pkg::mops_otp_t otp_cfg,
  input wire mops_pkg::mops_ch_cfg_t [mops_pkg::NCH-1:0] otp_ch,
  input wire mops_pkg::mops_wr_t host_wr,
  output mops_pkg::mops_drv_t [mops_pkg::NCH-1:0] out_drv,
  output logic bias_en,
  output logic [1:0] uv_ov_window,
  output logic int_o,
  output logic int_oe,
  output logic spi_access,
  output logic i2c_access
);
  import mops_pkg::*;
  mops_st_t r_reg;
  mops_st_t r_next;
  mops_pin_t pin_in;
  mops_pin_t p;
  logic [NCH-1:0] req;
  logic [NCH-1:0] off_v;
  logic [NCH-1:0] pin_on;
  logic [NSRC-1:0] src;
  logic boot_done;
  logic ms_tick;
  logic wd_on;
  logic wd_done;

  // ==========================================================
  // Pin capture and shared timers
  assign pin_in = {master_en_pin, en_a_pin, en_b_pin, watchdog_restore_pin,
                   interface_select_pad, ot_fault, oc_fault, ov_fault,
                   uv_fault, ramp_done, below_250mv};
  assign p = r_reg.s2;
  assign pin_on = {{(NCH - 2){1'b1}}, p.en_b, p.en_a};
  assign src = {p.ot, p.oc, p.ov, p.uv} & ~r_reg.g.int_mask;
  assign wd_on = r_reg.sq == SQ_RUN &&
                 (p.wd == r_reg.g.wd_act_high);

  for (genvar i = 0; i < NCH; i++) begin : g_req
    assign req[i] = r_reg.cfg[i].en &&
                    (r_reg.g.pin_mode != PM_ENPIN || pin_on[i]);
    assign off_v[i] = r_reg.st[i] == CH_OFF;
  end

  mops_timer u_boot (
    .clk(clk),
    .resetn(resetn),
    .run(r_reg.sq == SQ_BOOT),
    .limit(TW'(BOOT_CYC_P - 1)),
    .done(boot_done)
  );

  mops_timer u_ms (
    .clk(clk),
    .resetn(resetn),
    .run(!ms_tick),
    .limit(TW'(MS_CYC_P - 1)),
    .done(ms_tick)
  );

  mops_timer u_wdog (
    .clk(clk),
    .resetn(resetn),
    .run(wd_on),
    .limit(TW'(WDOG_CYC_P - 1)),
    .done(wd_done)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic act;
    logic live;
    act = 1'b0;
    live = 1'b0;
    r_next = r_reg;
    r_next.s1 = pin_in;
    r_next.s2 = r_reg.s1;
    r_next.men_q = p.men;
    unique case (r_reg.sq)
      SQ_SHUT: begin
        r_next.pd = '0;
        if (p.men && !r_reg.men_q) begin
          r_next.sq = SQ_BOOT;
        end
      end
      SQ_BOOT: begin
        if (!p.men) begin
          r_next.sq = SQ_SHUT;
        end else if (boot_done) begin
          r_next.sq = SQ_RUN;
          r_next.g = otp_cfg;
          r_next.cfg = otp_ch;
          r_next.pend = {NCH{otp_cfg.auto_start}};
          for (int i = 0; i < NCH; i++) begin
            r_next.hi[i] = otp_ch[i].code[CODE_W-1:LO_W];
          end
        end
      end
      SQ_RUN: begin
        if (!p.men) begin
          r_next.sq = SQ_PDN;
        end
      end
      SQ_PDN: begin
        if (&off_v) begin
          r_next.sq = SQ_SHUT;
        end
      end
    endcase
    // Host register writes
    if (host_wr.valid && r_reg.sq == SQ_RUN) begin
      unique case (host_wr.sel)
        WR_CODE_HI: begin
          r_next.hi[host_wr.ch] = host_wr.data;
        end
        WR_CODE_LO: begin
          r_next.cfg[host_wr.ch].code = {r_reg.hi[host_wr.ch],
              host_wr.data[LO_W-1:0]};
        end
        WR_ENABLE: begin
          r_next.cfg[host_wr.ch].en = host_wr.data[EN_BIT];
          r_next.cfg[host_wr.ch].dis = host_wr.data[DIS_BIT];
        end
        WR_SLEW: begin
          r_next.cfg[host_wr.ch].rise =
              host_wr.data[RISE_LSB +: SLEW_W];
          r_next.cfg[host_wr.ch].fall =
              host_wr.data[FALL_LSB +: SLEW_W];
        end
      endcase
    end
    // Watchdog restore of defaults
    if (wd_done) begin
      for (int i = 0; i < NCH; i++) begin
        r_next.cfg[i].code = otp_ch[i].code;
        r_next.hi[i] = otp_ch[i].code[CODE_W-1:LO_W];
      end
    end
    // Output channels
    for (int i = 0; i < NCH; i++) begin
      act = r_reg.st[i] inside {CH_SDLY, CH_UP, CH_ON};
      live = r_reg.st[i] inside {CH_UP, CH_ON};
      if (act && r_reg.sq == SQ_PDN) begin
        r_next.st[i] = CH_DDLY;
        r_next.cnt[i] = '0;
        r_next.moff[i] = 1'b1;
      end else if (act && p.ot) begin
        r_next.st[i] = CH_OFF;
      end else if (live && p.ov[i]) begin
        r_next.st[i] = CH_CROW;
        r_next.cnt[i] = '0;
      end else if (live && p.oc[i]) begin
        r_next.st[i] = CH_FLT;
        r_next.cnt[i] = '0;
      end else if (r_reg.st[i] == CH_ON && p.uv[i]) begin
        r_next.st[i] = CH_FLT;
        r_next.cnt[i] = '0;
      end else if (act && !req[i]) begin
        r_next.st[i] = live ? CH_DN : CH_OFF;
        r_next.moff[i] = 1'b0;
        r_next.pend[i] = 1'b0;
      end else begin
        unique case (r_reg.st[i])
          CH_OFF: begin
            if (r_reg.sq == SQ_RUN && req[i] && !p.ot) begin
              r_next.pd[i] = 1'b0;
              r_next.cnt[i] = '0;
              r_next.st[i] = r_reg.pend[i] ? CH_SDLY : CH_UP;
            end
          end
          CH_SDLY: begin
            if (r_reg.cnt[i][DLY_W-1:0] == r_reg.cfg[i].up_dly) begin
              r_next.st[i] = CH_UP;
              r_next.pend[i] = 1'b0;
            end else if (ms_tick) begin
              r_next.cnt[i] = r_reg.cnt[i] + 1'b1;
            end
          end
          CH_UP: begin
            if (p.rdone[i]) begin
              r_next.st[i] = CH_ON;
            end
          end
          CH_ON: begin
          end
          CH_DDLY: begin
            if (r_reg.cnt[i][DLY_W-1:0] == r_reg.cfg[i].dn_dly) begin
              r_next.st[i] = CH_DN;
            end else if (ms_tick) begin
              r_next.cnt[i] = r_reg.cnt[i] + 1'b1;
            end
          end
          CH_DN: begin
            if (p.low[i]) begin
              r_next.st[i] = CH_OFF;
              r_next.pd[i] = !r_reg.moff[i];
            end
          end
          CH_CROW: begin
            if (r_reg.cnt[i] == CW'(CROW_CYC_P - 1)) begin
              r_next.st[i] = CH_FLT;
              r_next.cnt[i] = '0;
            end else begin
              r_next.cnt[i] = r_reg.cnt[i] + 1'b1;
            end
          end
          CH_FLT: begin
            if (r_reg.sq != SQ_RUN || r_reg.cnt[i] == CW'(RETRY_MS)) begin
              r_next.st[i] = CH_OFF;
            end else if (ms_tick) begin
              r_next.cnt[i] = r_reg.cnt[i] + 1'b1;
            end
          end
        endcase
      end
      r_next.drv[i].on = r_next.st[i] inside {CH_UP, CH_ON, CH_DDLY, CH_DN};
      r_next.drv[i].ramp_up = r_next.st[i] == CH_UP;
      r_next.drv[i].ramp_dn = r_next.st[i] == CH_DN;
      r_next.drv[i].hiz = r_next.st[i] == CH_FLT;
      r_next.drv[i].lowside = r_next.st[i] == CH_CROW;
      r_next.drv[i].weak_pd = r_next.st[i] == CH_OFF && r_next.pd[i] &&
                              r_next.cfg[i].dis;
      r_next.drv[i].code = r_next.cfg[i].code;
      if (r_next.st[i] == CH_UP) begin
        r_next.drv[i].slew = r_next.cfg[i].pup;
      end else if (r_next.st[i] == CH_DN) begin
        r_next.drv[i].slew = r_next.cfg[i].pdn;
      end else if (r_next.cfg[i].code > r_reg.drv[i].code) begin
        r_next.drv[i].slew = r_next.cfg[i].rise;
      end else if (r_next.cfg[i].code < r_reg.drv[i].code) begin
        r_next.drv[i].slew = r_next.cfg[i].fall;
      end
    end
    // Bias, interrupt and access path
    r_next.bias = r_next.sq != SQ_SHUT;
    r_next.irq = |src;
    r_next.int_oe = r_reg.g.int_od ? r_next.irq : 1'b1;
    r_next.int_o = r_reg.g.int_od ? 1'b0 :
                   (r_next.irq == r_reg.g.int_act_high);
    r_next.spi = r_reg.g.pin_mode == PM_SPI && !p.pad;
    r_next.i2c = !r_next.spi;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.sq <= SQ_SHUT;
      for (int i = 0; i < NCH; i++) begin
        r_reg.st[i] <= CH_OFF;
      end
    end else begin
      r_reg <= r_next;
    end
  end

  assign out_drv = r_reg.drv;
  assign bias_en = r_reg.bias;
  assign uv_ov_window = r_reg.g.window;
  assign int_o = r_reg.int_o;
  assign int_oe = r_reg.int_oe;
  assign spi_access = r_reg.spi;
  assign i2c_access = r_reg.i2c;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  hi_hold_a: assert property (
    host_wr.valid && host_wr.sel == WR_CODE_HI && host_wr.ch == 2'h0 &&
    !wd_done && r_reg.sq == SQ_RUN |=> $stable(out_drv[0].code))
    else $error("code moved on high byte write");
  lo_commit_a: assert property (
    host_wr.valid && host_wr.sel == WR_CODE_LO && host_wr.ch == 2'h0 &&
    !wd_done && r_reg.sq == SQ_RUN |=>
    out_drv[0].code == {$past(r_reg.hi[0]), $past(host_wr.data[1:0])})
    else $error("low byte write did not commit code");
  boot_start_a: assert property (
    r_reg.sq == SQ_SHUT && p.men && !r_reg.men_q |=> bias_en ##0
    r_reg.sq == SQ_BOOT)
    else $error("no boot on master enable rise");
  manual_start_a: assert property (
    r_reg.st[0] == CH_OFF && r_reg.sq == SQ_RUN && req[0] &&
    !r_reg.pend[0] && !p.ot |=> out_drv[0].ramp_up)
    else $error("manual start delayed");
  manual_off_a: assert property (
    r_reg.st[0] == CH_ON && r_reg.sq == SQ_RUN && !req[0] && !p.ot &&
    !p.ov[0] && !p.oc[0] && !p.uv[0] |=> out_drv[0].ramp_dn)
    else $error("manual power-down not immediate");
  master_off_a: assert property (
    r_reg.st[0] == CH_ON && r_reg.sq == SQ_PDN |=>
    r_reg.st[0] == CH_DDLY && !out_drv[0].ramp_dn)
    else $error("master off skipped shutdown delay");
  passive_a: assert property (
    $rose(r_reg.st[0] == CH_OFF) && r_reg.moff[0] |-> !out_drv[0].weak_pd)
    else $error("pull-down after master shutdown");
  wd_restore_a: assert property (
    wd_done |=> out_drv[0].code == $past(otp_ch[0].code))
    else $error("watchdog did not restore default code");
  ot_off_a: assert property (
    p.ot && r_reg.st[0] == CH_ON && r_reg.sq == SQ_RUN |=> !out_drv[0].on)
    else $error("output stayed on in over-temperature");
  crow_end_a: assert property (
    $fell(out_drv[0].lowside) |-> out_drv[0].hiz && !out_drv[0].on)
    else $error("crowbar not followed by shutdown");
  access_a: assert property (
    r_reg.g.pin_mode == PM_SPI && !p.pad |=> spi_access && !i2c_access)
    else $error("wrong register access path");
  irq_a: assert property (
    |src |=> r_reg.irq ##0 (int_oe || !r_reg.g.int_od))
    else $error("unmasked fault gave no interrupt");

  boot_run_c: cover property (r_reg.sq == SQ_BOOT ##1 r_reg.sq == SQ_RUN);
  ch_on_c: cover property (out_drv[0].ramp_up ##1 r_reg.st[0] == CH_ON);
  wd_c: cover property (wd_done);
  crow_c: cover property ($fell(out_drv[0].lowside));
endmodule // mops_seq

// File: hdl/mops_pkg.sv
package mops_pkg;
  // ==========================================================
  // Sizes
  localparam int NCH = 4;
  localparam int CODE_W = 10;
  localparam int HI_W = 8;
  localparam int LO_W = 2;
  localparam int DLY_W = 6;
  localparam int SLEW_W = 3;
  localparam int TW = 24;
  localparam int CW = 13;
  localparam int NSRC = 1 + 3 * NCH;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int T_MS_US = 1000;
  localparam int MS_CYC = T_MS_US * CLK_MHZ;
  localparam int T_BOOT_US = 1400;
  localparam int BOOT_CYC = T_BOOT_US * CLK_MHZ;
  localparam int T_WDOG_MS = 10;
  localparam int WDOG_CYC = T_WDOG_MS * MS_CYC;
  localparam int T_CROW_US = 32;
  localparam int CROW_CYC = T_CROW_US * CLK_MHZ;
  localparam int RETRY_MS = 2;
  // ==========================================================
  // Codes and field positions
  localparam logic [2:0] PM_SPI = 3'h0;
  localparam logic [2:0] PM_ENPIN = 3'h1;
  localparam logic [1:0] WR_CODE_HI = 2'h0;
  localparam logic [1:0] WR_CODE_LO = 2'h1;
  localparam logic [1:0] WR_ENABLE = 2'h2;
  localparam logic [1:0] WR_SLEW = 2'h3;
  localparam int EN_BIT = 0;
  localparam int DIS_BIT = 1;
  localparam int RISE_LSB = 0;
  localparam int FALL_LSB = 3;
  // ==========================================================
  // Types
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic en;
    logic dis;
    logic [DLY_W-1:0] up_dly;
    logic [DLY_W-1:0] dn_dly;
    logic [SLEW_W-1:0] pup;
    logic [SLEW_W-1:0] pdn;
    logic [SLEW_W-1:0] rise;
    logic [SLEW_W-1:0] fall;
  } mops_ch_cfg_t;
  typedef struct packed {
    logic auto_start;
    logic [2:0] pin_mode;
    logic wd_act_high;
    logic int_act_high;
    logic int_od;
    logic [1:0] window;
    logic [NSRC-1:0] int_mask;
  } mops_otp_t;
  typedef struct packed {
    logic valid;
    logic [1:0] ch;
    logic [1:0] sel;
    logic [HI_W-1:0] data;
  } mops_wr_t;
  typedef struct packed {
    logic on;
    logic ramp_up;
    logic ramp_dn;
    logic [SLEW_W-1:0] slew;
    logic hiz;
    logic lowside;
    logic weak_pd;
    logic [CODE_W-1:0] code;
  } mops_drv_t;
  typedef struct packed {
    logic men;
    logic en_a;
    logic en_b;
    logic wd;
    logic pad;
    logic ot;
    logic [NCH-1:0] oc;
    logic [NCH-1:0] ov;
    logic [NCH-1:0] uv;
    logic [NCH-1:0] rdone;
    logic [NCH-1:0] low;
  } mops_pin_t;
  typedef enum logic [7:0] {
    CH_OFF = 8'h01, CH_SDLY = 8'h02, CH_UP = 8'h04, CH_ON = 8'h08,
    CH_DDLY = 8'h10, CH_DN = 8'h20, CH_CROW = 8'h40, CH_FLT = 8'h80
  } mops_ch_st_t;
  typedef enum logic [3:0] {
    SQ_SHUT = 4'h1, SQ_BOOT = 4'h2, SQ_RUN = 4'h4, SQ_PDN = 4'h8
  } mops_sq_st_t;
  typedef struct packed {
    logic [TW-1:0] cnt;
    logic done;
  } mops_tmr_t;
  typedef struct packed {
    mops_sq_st_t sq;
    mops_pin_t s1;
    mops_pin_t s2;
    logic men_q;
    mops_otp_t g;
    mops_ch_cfg_t [NCH-1:0] cfg;
    logic [NCH-1:0][HI_W-1:0] hi;
    mops_ch_st_t [NCH-1:0] st;
    logic [NCH-1:0][CW-1:0] cnt;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] moff;
    logic [NCH-1:0] pd;
    mops_drv_t [NCH-1:0] drv;
    logic bias;
    logic irq;
    logic int_o;
    logic int_oe;
    logic spi;
    logic i2c;
  } mops_st_t;
endpackage

// File: hdl/mops_timer.sv
`timescale 1ns/10ps
// ==========================================================
// Saturating counter, one-cycle done pulse, clears when idle
module mops_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [mops_pkg::TW-1:0] limit,
  output logic done
);
  import mops_pkg::*;
  mops_tmr_t r_reg;
  mops_tmr_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (!run) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt != limit) begin
      r_next.cnt = r_reg.cnt + 1'b1;
      r_next.done = (r_reg.cnt == limit - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;
endmodule // mops_timer

// File: dv/mops_host.sv
`timescale 1ns/10ps
// ==========================================================
// Host write driver and output stage response
module mops_host
  import mops_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire mops_pkg::mops_drv_t [mops_pkg::NCH-1:0] out_drv,
  output mops_pkg::mops_wr_t host_wr,
  output logic [mops_pkg::NCH-1:0] ramp_done,
  output logic [mops_pkg::NCH-1:0] below_250mv
);
  import mops_pkg::*;
  logic [NCH-1:0][2:0] cnt;
  initial host_wr = '0;
  // ==========================================================
  // One-cycle write pulse; the bench waits after a path switch
  task automatic write(input logic [1:0] ch, input logic [1:0] sel,
      input logic [7:0] data);
    @(posedge clk);
    host_wr <= '{valid: 1'b1, ch: ch, sel: sel, data: data};
    @(posedge clk);
    host_wr <= '0;
  endtask
  // ==========================================================
  // Ramps take eight cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (out_drv[i].ramp_up || out_drv[i].ramp_dn) begin
          if (cnt[i] != 3'h7) cnt[i] <= cnt[i] + 3'h1;
        end else begin
          cnt[i] <= 3'h0;
        end
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ramp_done[i] = out_drv[i].on && !out_drv[i].ramp_dn &&
        (!out_drv[i].ramp_up || cnt[i] == 3'h7);
      below_250mv[i] = !out_drv[i].on ||
        (out_drv[i].ramp_dn && cnt[i] == 3'h7);
    end
  end
endmodule // mops_host

// File: dv/testbench.sv
`timescale 1ns/10ps
// ==========================================================
// Sequencer bench
module testbench;
  import mops_pkg::*;
  localparam int LIM = 400;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic master = 1'b0;
  logic wd = 1'b1;
  logic ot = 1'b0;
  logic [NCH-1:0] oc = '0;
  logic [NCH-1:0] ov = '0;
  logic [NCH-1:0] uv = '0;
  logic en_a = 1'b0;
  logic en_b = 1'b0;
  logic pad = 1'b0;
  logic [NCH-1:0] rdone, below;
  mops_otp_t otp;
  mops_ch_cfg_t [NCH-1:0] och;
  mops_wr_t wr;
  mops_drv_t [NCH-1:0] out_drv;
  logic bias_en, int_o, int_oe, spi_access, i2c_access;
  logic [1:0] win, ch;
  logic [7:0] hi, lo;
  logic [5:0] sl;
  int errors = 0;
  int n_tests = 0;
  int seed = 32'h7c90;
  int last_k;
  logic [9:0] exp_code [NCH];
  logic [2:0] rise_e [NCH];
  logic [2:0] fall_e [NCH];

  always #2 clk = ~clk;

  mops_seq #(.BOOT_CYC_P(20), .MS_CYC_P(10), .WDOG_CYC_P(50),
    .CROW_CYC_P(8)) mops_seq_i (
    .clk(clk), .resetn(resetn), .master_en_pin(master),
    .en_a_pin(en_a), .en_b_pin(en_b), .watchdog_restore_pin(wd),
    .interface_select_pad(pad), .ot_fault(ot), .oc_fault(oc),
    .ov_fault(ov), .uv_fault(uv), .ramp_done(rdone),
    .below_250mv(below), .otp_cfg(otp), .otp_ch(och), .host_wr(wr),
    .out_drv(out_drv), .bias_en(bias_en), .uv_ov_window(win),
    .int_o(int_o), .int_oe(int_oe), .spi_access(spi_access),
    .i2c_access(i2c_access));
  mops_host mops_host_i (.clk(clk), .resetn(resetn), .out_drv(out_drv),
    .host_wr(wr), .ramp_done(rdone), .below_250mv(below));

  // ==========================================================
  // Helpers
  task automatic complete_run();
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    n_tests++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic fld(input int c, input int f);
    case (f)
      0: return out_drv[c].on;
      1: return out_drv[c].ramp_up;
      2: return out_drv[c].ramp_dn;
      3: return out_drv[c].hiz;
      4: return out_drv[c].lowside;
      5: return bias_en;
      default: return spi_access;
    endcase
  endfunction
  task automatic wait_fld(input int c, input int f, input logic v);
    int k;
    k = 0;
    while (fld(c, f) !== v) begin
      if (k == LIM) begin
        errors++;
        $display("[ERR] %0t wait ran out", $time);
        complete_run();
      end
      tick(1);
      k++;
    end
    n_tests++;
    last_k = k;
  endtask
  function automatic logic [2:0] want_slew(input logic [9:0] old_c,
      input logic [9:0] new_c, input logic [1:0] c);
    return (new_c > old_c) ? rise_e[c] : fall_e[c];
  endfunction
  task automatic wd_low(input int n);
    @(posedge clk);
    wd <= 1'b0;
    repeat (n) @(posedge clk);
    wd <= 1'b1;
    tick(4);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    otp = '{auto_start: 1'b0, pin_mode: PM_SPI, wd_act_high: 1'b0,
      int_act_high: 1'b0, int_od: 1'b0, window: 2'h1, int_mask: '0};
    for (int i = 0; i < NCH; i++) begin
      och[i] = '{code: 10'h100 + 10'(i), en: 1'b0, dis: 1'b1,
        up_dly: 6'h1, dn_dly: 6'h3, pup: 3'h2, pdn: 3'h5, rise: 3'h1,
        fall: 3'h6};
      exp_code[i] = och[i].code;
      rise_e[i] = 3'h1;
      fall_e[i] = 3'h6;
    end
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    tick(2);
    check(10'({int_oe, int_o, i2c_access, spi_access, bias_en}), 10'h1A);
    @(posedge clk);
    master <= 1'b1;
    wait_fld(0, 5, 1'b1);
    tick(22);
    wait_fld(0, 6, 1'b1);
    check(10'({i2c_access, win}), 10'h1);
    for (int i = 0; i < NCH; i++) begin
      check(out_drv[i].code, exp_code[i]);
      check(10'(out_drv[i].on), 10'h0);
    end
    for (int i = 0; i < NCH; i++) begin
      mops_host_i.write(2'(i), WR_ENABLE, 8'h03);
      tick(1);
      check(10'({out_drv[i].on, out_drv[i].ramp_up, out_drv[i].slew}),
        10'h1A);
      wait_fld(i, 1, 1'b0);
    end
    for (int n = 0; n < 10; n++) begin
      ch = 2'($random(seed));
      hi = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($random(seed));
      lo = (n == 0) ? 8'h03 : 8'($random(seed));
      sl = 6'($random(seed));
      mops_host_i.write(ch, WR_SLEW, {2'h0, sl});
      rise_e[ch] = sl[2:0];
      fall_e[ch] = sl[5:3];
      mops_host_i.write(ch, WR_CODE_HI, hi);
      tick(1);
      check(out_drv[ch].code, exp_code[ch]);
      mops_host_i.write(ch, WR_CODE_LO, lo);
      tick(1);
      check(out_drv[ch].code, {hi, lo[1:0]});
      if ({hi, lo[1:0]} != exp_code[ch])
        check(10'(out_drv[ch].slew),
          10'(want_slew(exp_code[ch], {hi, lo[1:0]}, ch)));
      exp_code[ch] = {hi, lo[1:0]};
      tick(20);
    end
    @(posedge clk);
    pad <= 1'b1;
    wait_fld(0, 6, 1'b0);
    check(10'(i2c_access), 10'h1);
    @(posedge clk);
    pad <= 1'b0;
    wait_fld(0, 6, 1'b1);
    tick(13);
    wd_low(30);
    wd_low(30);
    for (int i = 0; i < NCH; i++)
      check(out_drv[i].code, exp_code[i]);
    wd_low(70);
    for (int i = 0; i < NCH; i++)
      check(out_drv[i].code, och[i].code);
    @(posedge clk);
    ot <= 1'b1;
    wait_fld(0, 0, 1'b0);
    check(10'({out_drv[3].on, int_oe, int_o}), 10'h2);
    @(posedge clk);
    ot <= 1'b0;
    wait_fld(0, 0, 1'b1);
    tick(3);
    check(10'(int_o), 10'h1);
    @(posedge clk);
    oc[2] <= 1'b1;
    wait_fld(2, 3, 1'b1);
    check(10'(int_o), 10'h0);
    @(posedge clk);
    oc[2] <= 1'b0;
    wait_fld(2, 3, 1'b0);
    wait_fld(2, 0, 1'b1);
    @(posedge clk);
    uv[0] <= 1'b1;
    wait_fld(0, 3, 1'b1);
    check(10'(int_o), 10'h0);
    @(posedge clk);
    uv[0] <= 1'b0;
    wait_fld(0, 3, 1'b0);
    wait_fld(0, 0, 1'b1);
    @(posedge clk);
    ov[3] <= 1'b1;
    wait_fld(3, 4, 1'b1);
    wait_fld(3, 4, 1'b0);
    check(10'(last_k), 10'h8);
    @(posedge clk);
    ov[3] <= 1'b0;
    wait_fld(3, 0, 1'b1);
    mops_host_i.write(2'h1, WR_ENABLE, 8'h02);
    tick(1);
    check(10'({out_drv[1].ramp_dn, out_drv[1].slew}), 10'hD);
    wait_fld(1, 0, 1'b0);
    check(10'(out_drv[1].weak_pd), 10'h1);
    @(posedge clk);
    master <= 1'b0;
    tick(8);
    check(10'(out_drv[0].ramp_dn), 10'h0);
    wait_fld(0, 2, 1'b1);
    check(10'(out_drv[0].slew), 10'h5);
    wait_fld(0, 0, 1'b0);
    check(10'(out_drv[0].weak_pd), 10'h0);
    wait_fld(0, 5, 1'b0);
    @(posedge clk);
    otp.pin_mode <= PM_ENPIN;
    otp.auto_start <= 1'b1;
    for (int i = 0; i < NCH; i++)
      och[i].en <= 1'b1;
    en_a <= 1'b1;
    @(posedge clk);
    master <= 1'b1;
    wait_fld(0, 5, 1'b1);
    tick(22);
    check(10'({i2c_access, out_drv[3].on, out_drv[1].on, out_drv[0].on}),
      10'h8);
    wait_fld(0, 1, 1'b1);
    check(10'({out_drv[1].on, out_drv[0].slew}), 10'h2);
    @(posedge clk);
    en_b <= 1'b1;
    wait_fld(1, 0, 1'b1);
    @(posedge clk);
    en_a <= 1'b0;
    wait_fld(0, 2, 1'b1);
    check(10'(last_k < 5), 10'h1);
    complete_run();
  end
endmodule // testbench
